// ---- dv/sleep_mode_clock_gating_bench.sv ----
// Self-checking bench of the sleep controller
`timescale 1ns/1ps
module sleep_mode_clock_gating_bench;
	logic clk = 0, rst = 1, sen = 1, go = 0, rtc = 1, cpu, rtco, sl, req;
	logic [2:0] mi = 3'h0, mo;
	logic [3:0] osc = 4'h9, oscr;
	logic [7:0] gate = 8'hA5, per;
	logic [5:0] src = 6'h0;
	int n_mismatch = 0, n_tests = 0, cyc = 0;
	always #10 clk = ~clk;
	slp_cpu_model CPU (.clk(clk), .go(go), .mode_in(mi), .cpu_clk_en(cpu),
		.sleep_req(req), .sleep_mode(mo));
	slp_ctrl #(.OSC_START(16'h3), .STBY_START(16'h1)) DUT (.CLOCK(clk),
		.RST(rst), .SLEEP_EN(sen), .SLEEP_MODE(mo), .SLEEP_REQ(req),
		.RTC_EN(rtc), .OSC_EN(osc), .PER_GATE(gate),
		.TWO_WIRE_SERIAL_PORT_IRQ(src[0]), .USB_RESUME(src[1]),
		.PIN_CHANGE_IRQ(src[2]), .RTC_OVF_IRQ(src[3]), .RTC_CMP_IRQ(src[4]),
		.IRQ_ANY(src[5]), .CPU_CLK_EN(cpu), .PER_CLK_EN(per),
		.RTC_CLK_EN(rtco), .OSC_RUN(oscr), .SLEEPING(sl));
	task test_done;
		$display("mismatches %0d tests %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done;
		end
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h want %h", $time, g, e);
		end
	endtask
	task snap(input logic c, input logic [7:0] p, input logic r,
		input logic [3:0] o, input logic s);
		chk({1'b0, cpu, rtco, sl, oscr}, {1'b0, c, r, s, o});
		chk(per, p);
	endtask
	task sleep_in(input logic [2:0] m);
		@(posedge clk);
		go <= 1;
		mi <= m;
		@(posedge clk);
		go <= 0;
		@(posedge clk);
		@(negedge clk);
	endtask
	// Raise one source, count cycles until the core clock is back
	task wake(input int i, input int lo, input int hi);
		int k;
		k = 0;
		@(posedge clk);
		src[i] <= 1;
		do begin
			@(negedge clk);
			k++;
		end while (cpu !== 1'b1 && k < 20);
		chk(8'(k >= lo && k <= hi), 8'h1);
		snap(1, ~gate, rtc, osc, 0);
		@(posedge clk);
		src[i] <= 0;
	endtask
	task t_idle;
		sleep_in(3'h0);
		snap(0, ~gate, 1, osc, 1);
		@(posedge clk);
		gate <= 8'h3C;
		repeat (2) @(negedge clk);
		chk(per, 8'hC3);
		wake(5, 2, 4);
	endtask
	task t_pdown;
		sleep_in(3'h2);
		snap(0, 0, 0, 0, 1);
		@(posedge clk);
		src[3] <= 1;
		repeat (6) @(negedge clk);
		chk({6'h0, cpu, sl}, 8'h1);
		@(posedge clk);
		src[3] <= 0;
		for (int i = 0; i < 3; i++) begin
			if (i > 0)
				sleep_in(3'h2);
			wake(i, 6, 8);
		end
		sleep_in(3'h2);
		@(posedge clk);
		rst <= 1;
		@(posedge clk);
		rst <= 0;
		@(negedge clk);
		chk({7'h0, cpu}, 8'h1);
	endtask
	task t_psave;
		sleep_in(3'h3);
		snap(0, 0, 1, 0, 1);
		wake(3, 6, 8);
		sleep_in(3'h3);
		wake(4, 6, 8);
	endtask
	task t_stdby;
		sleep_in(3'h6);
		snap(0, 0, 0, osc, 1);
		wake(2, 4, 6);
		sleep_in(3'h7);
		snap(0, 0, 1, osc, 1);
		wake(4, 4, 6);
	endtask
	// Counter disabled: no counter clock and no counter wake in power-save
	task t_rtc_off;
		@(posedge clk);
		rtc <= 0;
		sleep_in(3'h3);
		snap(0, 0, 0, 0, 1);
		@(posedge clk);
		src[5:3] <= 3'h7;
		repeat (6) @(negedge clk);
		chk({6'h0, cpu, sl}, 8'h1);
		@(posedge clk);
		src[5:3] <= 3'h0;
		wake(2, 6, 8);
		@(posedge clk);
		rtc <= 1;
	endtask
	task t_refuse;
		sleep_in(3'h1);
		snap(1, ~gate, 1, osc, 0);
		@(posedge clk);
		sen <= 0;
		sleep_in(3'h2);
		snap(1, ~gate, 1, osc, 0);
		@(posedge clk);
		sen <= 1;
	endtask
	initial begin
		repeat (11) @(posedge clk);
		@(negedge clk);
		snap(1, 8'hFF, 0, 4'hF, 0);
		@(posedge clk);
		rst <= 0;
		repeat (2) @(negedge clk);
		snap(1, ~gate, 1, osc, 0);
		t_idle;
		t_pdown;
		t_psave;
		t_rtc_off;
		t_stdby;
		t_refuse;
		test_done;
	end
endmodule

// ---- dv/slp_cpu_model.sv ----
// Processor core model that issues sleep instructions
`timescale 1ns/1ps
module slp_cpu_model (
	// Clock
	input wire logic clk,
	// Command from the bench
	input wire logic go,
	input wire logic [2:0] mode_in,
	// Sleep interface
	input wire logic cpu_clk_en,
	output logic sleep_req,
	output logic [2:0] sleep_mode
);
	initial sleep_req = 1'b0;
	initial sleep_mode = 3'h0;
	// An instruction issues only while the core is clocked
	always @(posedge clk) begin
		sleep_req <= go && cpu_clk_en && !sleep_req;
		sleep_mode <= mode_in;
	end
endmodule

// ---- verilog/slp_ctrl.sv ----
// Sleep mode sequencer and clock gate controller
//
// Operation
// - Five selectable sleep modes offered
// - Idle halts processor clock only
// - Power-down stops oscillators, keeps state
// - Power-down wakes: two-wire, USB, pin, reset
// - Power-save keeps enabled RTC running
// - Power-save also wakes on RTC interrupts
// - Standby keeps sources, stops CPU/peripheral/RTC
// - Extended standby keeps oscillator and RTC
// - Per-peripheral clock gate in active, idle
// - Extended standby is power-save plus sources
`timescale 1ns/1ps
`include "slp_params.svh"
module slp_ctrl
	import slp_pkg::*;
#(
	parameter int NPER = 8,
	parameter int NOSC = 4,
	parameter logic [`SLP_CNT_W-1:0] OSC_START = `SLP_CNT_W'(`SLP_OSC_START_CYC),
	parameter logic [`SLP_CNT_W-1:0] STBY_START = `SLP_CNT_W'(`SLP_STBY_START_CYC)
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RST,
	// Sleep control from the processor
	input wire logic SLEEP_EN,
	input wire logic [2:0] SLEEP_MODE,
	input wire logic SLEEP_REQ,
	input wire logic RTC_EN,
	input wire logic [NOSC-1:0] OSC_EN,
	input wire logic [NPER-1:0] PER_GATE,
	// Wake sources
	input wire logic TWO_WIRE_SERIAL_PORT_IRQ,
	input wire logic USB_RESUME,
	input wire logic PIN_CHANGE_IRQ,
	input wire logic RTC_OVF_IRQ,
	input wire logic RTC_CMP_IRQ,
	input wire logic IRQ_ANY,
	// Clock enables
	output logic CPU_CLK_EN,
	output logic [NPER-1:0] PER_CLK_EN,
	output logic RTC_CLK_EN,
	output logic [NOSC-1:0] OSC_RUN,
	output logic SLEEPING
);
	localparam int WAKE_MAX = int'(OSC_START) + 2;

	slp_state_t state;
	slp_state_t next_state;
	slp_mode_t mode;
	slp_mode_t next_mode;
	logic [`SLP_CNT_W-1:0] cnt;
	logic [`SLP_CNT_W-1:0] next_cnt;
	wire logic sleep_take;
	wire logic next_active;
	wire logic per_run;
	wire logic osc_run;
	wire logic rtc_run;
	wire logic [`SLP_CNT_W-1:0] start_cnt;

	slp_if link();

	slp_wake u_wake (
		.clk(CLOCK),
		.rst(RST),
		.src_raw({RTC_CMP_IRQ, RTC_OVF_IRQ, PIN_CHANGE_IRQ, USB_RESUME,
			TWO_WIRE_SERIAL_PORT_IRQ}),
		.irq_any(IRQ_ANY),
		.bus(link.wk)
	);

	assign link.sleeping = (state == ST_SLEEP);
	assign link.mode = mode;
	assign link.rtc_en = RTC_EN;

	// Undefined mode codes leave the request ignored
	assign sleep_take = (state == ST_ACTIVE) & SLEEP_REQ & SLEEP_EN
		& mode_valid(SLEEP_MODE);

	// Settling time depends on which sources were left running
	assign start_cnt = (mode == SLP_IDLE) ? `SLP_CNT_W'(0) :
		osc_kept(mode) ? STBY_START : OSC_START;

	always_comb begin
		next_state = state;
		next_mode = mode;
		next_cnt = cnt;
		case (state)
			ST_ACTIVE: begin
				if (sleep_take) begin
					next_state = ST_SLEEP;
					next_mode = slp_mode_t'(SLEEP_MODE);
				end
			end
			ST_SLEEP: begin
				if (link.wake) begin
					next_state = ST_WAKE;
					next_cnt = start_cnt;
				end
			end
			ST_WAKE: begin
				if (cnt == `SLP_CNT_W'(0)) begin
					next_state = ST_ACTIVE;
				end else begin
					next_cnt = cnt - `SLP_CNT_W'(1);
				end
			end
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	assign next_active = (next_state == ST_ACTIVE);
	// Idle keeps peripherals; every deeper mode stops them
	assign per_run = next_active | (next_mode == SLP_IDLE);
	// Sources restart as soon as a wake is seen
	assign osc_run = (next_state != ST_SLEEP) | osc_kept(next_mode);
	assign rtc_run = next_active | rtc_kept(next_mode);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state <= ST_ACTIVE;
			mode <= SLP_IDLE;
			cnt <= `SLP_CNT_W'(0);
		end else begin
			state <= next_state;
			mode <= next_mode;
			cnt <= next_cnt;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			CPU_CLK_EN <= `SLP_RST_CLK_EN;
			PER_CLK_EN <= {NPER{`SLP_RST_CLK_EN}};
			RTC_CLK_EN <= 1'b0;
			OSC_RUN <= {NOSC{`SLP_RST_CLK_EN}};
			SLEEPING <= 1'b0;
		end else begin
			CPU_CLK_EN <= next_active;
			PER_CLK_EN <= {NPER{per_run}} & ~PER_GATE;
			RTC_CLK_EN <= RTC_EN & rtc_run;
			OSC_RUN <= OSC_EN & {NOSC{osc_run}};
			SLEEPING <= ~next_active;
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	sequence enter_s;
		sleep_take;
	endsequence

	sequence wake_s;
		state == ST_SLEEP && link.wake;
	endsequence

	sleep_entry_a: assert property (
		enter_s |=> (state == ST_SLEEP && !CPU_CLK_EN && SLEEPING))
		else $error("accepted sleep request did not stop the processor");
	idle_per_a: assert property (
		(state == ST_SLEEP && mode == SLP_IDLE)
		|-> (!CPU_CLK_EN && PER_CLK_EN == ~$past(PER_GATE)))
		else $error("idle did not keep peripheral clocks");
	pdown_off_a: assert property (
		(state == ST_SLEEP && mode == SLP_PDOWN)
		|-> (OSC_RUN == '0 && PER_CLK_EN == '0 && !RTC_CLK_EN))
		else $error("power-down left a clock running");
	psave_rtc_a: assert property (
		(state == ST_SLEEP && mode == SLP_PSAVE)
		|-> (RTC_CLK_EN == $past(RTC_EN) && OSC_RUN == '0))
		else $error("power-save RTC clock wrong");
	stdby_osc_a: assert property (
		(state == ST_SLEEP && mode == SLP_STDBY)
		|-> (OSC_RUN == $past(OSC_EN) && !RTC_CLK_EN && PER_CLK_EN == '0))
		else $error("standby clock enables wrong");
	estdby_keep_a: assert property (
		(state == ST_SLEEP && mode == SLP_ESTDBY)
		|-> (OSC_RUN == $past(OSC_EN) && RTC_CLK_EN == $past(RTC_EN)
		&& PER_CLK_EN == '0))
		else $error("extended standby clock enables wrong");
	active_gate_a: assert property (
		(state == ST_ACTIVE && $past(state) == ST_ACTIVE && !$past(RST))
		|-> PER_CLK_EN == ~$past(PER_GATE))
		else $error("peripheral gate not applied in active mode");
	wake_resume_a: assert property (
		wake_s |=> (!CPU_CLK_EN && osc_run) ##[0:WAKE_MAX] CPU_CLK_EN)
		else $error("processor did not resume after wake");
	wake_cpu_off_a: assert property (
		state == ST_WAKE |-> !CPU_CLK_EN)
		else $error("processor clock ran before wake finished");
endmodule

// ---- verilog/slp_if.sv ----
// Link between the sleep sequencer and its wake qualifier
`timescale 1ns/1ps
interface slp_if;
	import slp_pkg::*;
	logic sleeping;
	slp_mode_t mode;
	logic rtc_en;
	logic wake;
	modport ctrl(output sleeping, output mode, output rtc_en, input wake);
	modport wk(input sleeping, input mode, input rtc_en, output wake);
endinterface

// ---- verilog/slp_params.svh ----
// Timing counts and reset values of the sleep controller
`ifndef SLP_PARAMS_SVH
`define SLP_PARAMS_SVH
`define SLP_CLK_PERIOD_NS 20
`define SLP_OSC_START_NS 1000
`define SLP_OSC_START_CYC ((`SLP_OSC_START_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS)
`define SLP_STBY_START_NS 20
`define SLP_STBY_START_CYC ((`SLP_STBY_START_NS + `SLP_CLK_PERIOD_NS - 1) / `SLP_CLK_PERIOD_NS)
`define SLP_RST_CLK_EN 1'b1
`define SLP_CNT_W 16
`endif

// ---- verilog/slp_pkg.sv ----
// Types and mode decode helpers of the sleep controller
package slp_pkg;
	typedef enum logic [2:0] {
		SLP_IDLE = 3'h0,
		SLP_PDOWN = 3'h2,
		SLP_PSAVE = 3'h3,
		SLP_STDBY = 3'h6,
		SLP_ESTDBY = 3'h7
	} slp_mode_t;

	typedef enum logic [2:0] {
		ST_ACTIVE = 3'h1,
		ST_SLEEP = 3'h2,
		ST_WAKE = 3'h4
	} slp_state_t;

	function automatic logic mode_valid(input logic [2:0] m);
		mode_valid = (m == SLP_IDLE) || (m == SLP_PDOWN) || (m == SLP_PSAVE)
			|| (m == SLP_STDBY) || (m == SLP_ESTDBY);
	endfunction

	// Real-time counter keeps its clock in these modes
	function automatic logic rtc_kept(input slp_mode_t m);
		rtc_kept = (m == SLP_IDLE) || (m == SLP_PSAVE) || (m == SLP_ESTDBY);
	endfunction

	// Enabled clock sources keep running in these modes
	function automatic logic osc_kept(input slp_mode_t m);
		osc_kept = (m == SLP_IDLE) || (m == SLP_STDBY) || (m == SLP_ESTDBY);
	endfunction
endpackage

// ---- verilog/slp_wake.sv ----
// Wake source synchroniser and per-mode qualifier
`timescale 1ns/1ps
module slp_wake
	import slp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] src_raw,
	input wire logic irq_any,
	slp_if.wk bus
);
	logic [4:0] sync1;
	logic [4:0] sync2;
	wire logic pd_src;
	wire logic rtc_src;
	wire logic rtc_ok;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end else begin
			sync1 <= src_raw;
			sync2 <= sync1;
		end
	end

	// Bits: 0 two-wire port, 1 USB resume, 2 pin change, 3/4 RTC
	assign pd_src = sync2[0] | sync2[1] | sync2[2];
	assign rtc_src = sync2[3] | sync2[4];
	assign rtc_ok = rtc_src & bus.rtc_en & rtc_kept(bus.mode);
	assign bus.wake = bus.sleeping & (pd_src | rtc_ok
		| ((bus.mode == SLP_IDLE) & irq_any));

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	pd_source_a: assert property (
		(bus.sleeping && bus.mode == SLP_PDOWN && bus.wake) |-> pd_src)
		else $error("power-down woke from a source it must ignore");
	rtc_wake_a: assert property (
		(bus.sleeping && bus.mode == SLP_PSAVE && bus.rtc_en && rtc_src)
		|-> bus.wake)
		else $error("RTC interrupt did not wake power-save");
	stdby_no_rtc_a: assert property (
		(bus.sleeping && bus.mode == SLP_STDBY && bus.wake) |-> pd_src)
		else $error("standby woke from a non power-down source");
endmodule
